// ### hw/pdaps_top.sv
// Powerdown state keeper: wake decode, register hold and pin states for the drive controller.
`timescale 1ns/10ps
module pdaps_top #(
  parameter int SHORT_CNT = pdaps_pkg::SHORT_CYCLES,
  parameter int LONG_CNT = pdaps_pkg::LONG_CYCLES
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Host bus, strobes active low, synchronous.
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] db_in,
  output logic [7:0] db_out,
  output logic db_oe,
  // Core status from the command engine.
  input wire logic [7:0] main_status_in,
  input wire logic head_loaded,
  input wire logic core_int,
  input wire logic core_dma_request,
  input wire logic [7:0] core_fifo_data,
  input wire logic [7:0] digital_input_in,
  // Auto powerdown command settings.
  input wire logic auto_pd_enable,
  input wire logic min_dly_long,
  input wire logic drive_interface_hold,
  input wire logic status_pin_enable,
  input wire logic extended_register_enable,
  // Core drive output levels.
  input wire logic [1:0] core_motor_on_n,
  input wire logic [1:0] core_drive_select_n,
  input wire logic core_dir_n,
  input wire logic core_step_n,
  input wire logic core_write_data_n,
  input wire logic core_write_gate_n,
  input wire logic core_head_select_n,
  input wire logic [1:0] core_density_select,
  // Drive inputs.
  input wire logic read_data_n,
  input wire logic write_protect_n,
  input wire logic track_zero_n,
  input wire logic index_pulse_n,
  input wire logic disk_change_n,
  input wire logic dma_grant_n,
  input wire logic terminal_count,
  // Gated drive and grant inputs to the core.
  output logic gated_read_data_n,
  output logic gated_write_protect_n,
  output logic gated_track_zero_n,
  output logic gated_index_pulse_n,
  output logic gated_disk_change_n,
  output logic gated_dma_grant_n,
  output logic gated_terminal_count,
  // Drive outputs with output enables.
  output logic [1:0] motor_on_n,
  output logic [1:0] motor_on_oe,
  output logic [1:0] drive_select_n,
  output logic [1:0] drive_select_oe,
  output logic [7:0] drive_misc_n,
  output logic drive_misc_oe,
  // System outputs and core controls.
  output logic dma_request,
  output logic interrupt,
  output logic powered_down,
  output logic core_soft_reset,
  output logic core_fifo_access,
  output logic [7:0] drive_output_control,
  output logic [7:0] rate_select_control,
  output logic [7:0] configuration_control,
  output logic [7:0] tape_drive_select,
  output logic [1:0] power_state
);
  pdaps_pkg::pdaps_state_t st_q;
  logic [7:0] dor_q, dsr_q, ccr_q, tdr_q, srb_q;
  logic [7:0] hold_q;
  logic [1:0] mot_hold_q, sel_hold_q;
  logic rd_acc, wr_acc, pd, wake, soft_rst, tmr_exp, idle;
  logic [7:0] rd_data;

  // Host bus is never gated by powerdown, so wake accesses are always seen.
  assign rd_acc = !cs_n && !rd_n;
  assign wr_acc = !cs_n && !wr_n;
  assign pd = (st_q != pdaps_pkg::PDAPS_ST_AWAKE);
  assign idle = (main_status_in == pdaps_pkg::MSR_IDLE) && !head_loaded && !core_int;

  // Software reset from the control register reset bits; writing 0 to the DOR reset bit or 1 to the DSR reset bit resets.
  assign soft_rst = wr_acc &&
    (((addr == pdaps_pkg::ADDR_DRIVE_OUT) && !db_in[pdaps_pkg::DOR_RESET_N_BIT]) ||
     ((addr == pdaps_pkg::ADDR_RATE_MAIN) && db_in[pdaps_pkg::DSR_RESET_BIT]));

  // Wake decode; extended register bits take no part in it.
  always_comb begin
    wake = 1'b0;
    if (rd_acc && (addr == pdaps_pkg::ADDR_RATE_MAIN)) begin
      wake = 1'b1;
    end else if ((rd_acc || wr_acc) && (addr == pdaps_pkg::ADDR_FIFO)) begin
      wake = 1'b1;
    end else if (wr_acc && (addr == pdaps_pkg::ADDR_DRIVE_OUT) &&
                 (db_in[pdaps_pkg::DOR_MOTOR_HI:pdaps_pkg::DOR_MOTOR_LO] != 2'b00)) begin
      wake = 1'b1;
    end
  end

  pdaps_wake_timer #(
    .SHORT_CNT(SHORT_CNT),
    .LONG_CNT(LONG_CNT)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .restart(soft_rst || (pd && wake) || !auto_pd_enable),
    .long_dly(min_dly_long),
    .expired(tmr_exp)
  );

  // Power state; a non-waking access leaves the state as it was, unless it writes a reset bit or the powerdown bit.
  always_ff @(posedge clk_sys) begin
    if (rst || soft_rst) begin
      st_q <= pdaps_pkg::PDAPS_ST_AWAKE;
    end else if (wr_acc && (addr == pdaps_pkg::ADDR_RATE_MAIN) &&
                 db_in[pdaps_pkg::DSR_PDOWN_BIT]) begin
      st_q <= pdaps_pkg::PDAPS_ST_DIRECT_PD;
    end else begin
      case (st_q)
        pdaps_pkg::PDAPS_ST_AWAKE: begin
          if (auto_pd_enable && tmr_exp && idle && !wake &&
              (core_motor_on_n == 2'b11)) begin
            st_q <= pdaps_pkg::PDAPS_ST_AUTO_PD;
          end
        end
        pdaps_pkg::PDAPS_ST_AUTO_PD: begin
          if (wake || !auto_pd_enable) begin
            st_q <= pdaps_pkg::PDAPS_ST_AWAKE;
          end
        end
        default: begin
          st_q <= st_q;
        end
      endcase
    end
  end

  // Registers keep their written values whatever the power state.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dor_q <= pdaps_pkg::DOR_RESET_VAL;
      dsr_q <= pdaps_pkg::DSR_RESET_VAL;
      ccr_q <= pdaps_pkg::ZERO_BYTE;
      tdr_q <= pdaps_pkg::ZERO_BYTE;
      srb_q <= pdaps_pkg::ZERO_BYTE;
    end else if (wr_acc) begin
      if (addr == pdaps_pkg::ADDR_STATUS_B) begin
        if (extended_register_enable) begin
          srb_q <= db_in;
        end
      end else if (addr == pdaps_pkg::ADDR_DRIVE_OUT) begin
        dor_q <= db_in;
      end else if (addr == pdaps_pkg::ADDR_TAPE_SEL) begin
        tdr_q <= db_in;
      end else if (addr == pdaps_pkg::ADDR_RATE_MAIN) begin
        dsr_q <= db_in;
      end else if (addr == pdaps_pkg::ADDR_DIGIN_CFG) begin
        ccr_q <= db_in;
      end
    end
  end

  // Reads return live values and are served in any power state.
  always_comb begin
    rd_data = pdaps_pkg::ZERO_BYTE;
    if (addr == pdaps_pkg::ADDR_STATUS_B) begin
      rd_data = extended_register_enable ? srb_q : pdaps_pkg::ZERO_BYTE;
    end else if (addr == pdaps_pkg::ADDR_DRIVE_OUT) begin
      rd_data = dor_q;
    end else if (addr == pdaps_pkg::ADDR_TAPE_SEL) begin
      rd_data = tdr_q;
    end else if (addr == pdaps_pkg::ADDR_RATE_MAIN) begin
      rd_data = main_status_in;
    end else if (addr == pdaps_pkg::ADDR_FIFO) begin
      rd_data = core_fifo_data;
    end else if (addr == pdaps_pkg::ADDR_DIGIN_CFG) begin
      rd_data = digital_input_in;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      db_out <= pdaps_pkg::ZERO_BYTE;
      db_oe <= 1'b0;
    end else begin
      db_out <= rd_data;
      db_oe <= rd_acc;
    end
  end

  // Levels captured while awake, so the hold option can freeze them.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_q <= 8'hFF;
      mot_hold_q <= 2'b11;
      sel_hold_q <= 2'b11;
    end else if (!pd) begin
      hold_q <= {core_dir_n, core_step_n, core_write_data_n, core_write_gate_n,
                 core_head_select_n, 1'b1, core_density_select};
      mot_hold_q <= core_motor_on_n;
      sel_hold_q <= core_drive_select_n;
    end
  end

  // Drive outputs; select one and motor one become status pins when enabled.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      motor_on_n <= 2'b11;
      motor_on_oe <= 2'b00;
      drive_select_n <= 2'b11;
      drive_select_oe <= 2'b00;
      drive_misc_n <= 8'hFF;
      drive_misc_oe <= 1'b0;
    end else begin
      motor_on_n[0] <= pd ? mot_hold_q[0] : core_motor_on_n[0];
      drive_select_n[0] <= pd ? sel_hold_q[0] : core_drive_select_n[0];
      motor_on_oe[0] <= !pd || drive_interface_hold;
      drive_select_oe[0] <= !pd || drive_interface_hold;
      drive_misc_n <= pd ? hold_q : {core_dir_n, core_step_n, core_write_data_n,
                      core_write_gate_n, core_head_select_n, 1'b1, core_density_select};
      drive_misc_oe <= !pd || drive_interface_hold;
      if (status_pin_enable) begin
        // Status pins are local logic signals, driven regardless of powerdown.
        drive_select_n[1] <= pd;
        motor_on_n[1] <= (st_q == pdaps_pkg::PDAPS_ST_AUTO_PD) ||
                         (!pd && idle && !srb_q[pdaps_pkg::SRB_MASK_IDLE_BIT]);
        drive_select_oe[1] <= 1'b1;
        motor_on_oe[1] <= 1'b1;
      end else begin
        motor_on_n[1] <= pd ? mot_hold_q[1] : core_motor_on_n[1];
        drive_select_n[1] <= pd ? sel_hold_q[1] : core_drive_select_n[1];
        motor_on_oe[1] <= !pd || drive_interface_hold;
        drive_select_oe[1] <= !pd || drive_interface_hold;
      end
    end
  end

  // Inputs held at inactive levels in powerdown; request and interrupt driven low.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gated_read_data_n <= 1'b1;
      gated_write_protect_n <= 1'b1;
      gated_track_zero_n <= 1'b1;
      gated_index_pulse_n <= 1'b1;
      gated_disk_change_n <= 1'b1;
      gated_dma_grant_n <= 1'b1;
      gated_terminal_count <= 1'b0;
      dma_request <= 1'b0;
      interrupt <= 1'b0;
    end else begin
      gated_read_data_n <= pd || read_data_n;
      gated_write_protect_n <= pd || write_protect_n;
      gated_track_zero_n <= pd || track_zero_n;
      gated_index_pulse_n <= pd || index_pulse_n;
      gated_disk_change_n <= pd || disk_change_n;
      gated_dma_grant_n <= pd || dma_grant_n;
      gated_terminal_count <= !pd && terminal_count;
      dma_request <= !pd && core_dma_request;
      interrupt <= !pd && core_int;
    end
  end

  // Status and core control outputs.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      powered_down <= 1'b0;
      core_soft_reset <= 1'b0;
      core_fifo_access <= 1'b0;
      power_state <= 2'b00;
      drive_output_control <= pdaps_pkg::DOR_RESET_VAL;
      rate_select_control <= pdaps_pkg::DSR_RESET_VAL;
      configuration_control <= pdaps_pkg::ZERO_BYTE;
      tape_drive_select <= pdaps_pkg::ZERO_BYTE;
    end else begin
      powered_down <= pd;
      core_soft_reset <= soft_rst;
      core_fifo_access <= (rd_acc || wr_acc) && (addr == pdaps_pkg::ADDR_FIFO);
      power_state <= st_q;
      if (!pd) begin
        // Values written in powerdown reach the core only once awake.
        drive_output_control <= dor_q;
        rate_select_control <= dsr_q;
        configuration_control <= ccr_q;
        tape_drive_select <= tdr_q;
      end
    end
  end

  // Extended register enable only touches read/write visibility, never the state.
  chk_direct_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q == pdaps_pkg::PDAPS_ST_DIRECT_PD) && !soft_rst && !rst
    |=> st_q == pdaps_pkg::PDAPS_ST_DIRECT_PD)
    else $error("direct powerdown left without reset");
  chk_pin_follows_pd: assert property (@(posedge clk_sys) disable iff (rst)
    pd |=> powered_down)
    else $error("powered_down not high in powerdown");
  chk_fifo_wakes: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q == pdaps_pkg::PDAPS_ST_AUTO_PD) && rd_acc && (addr == pdaps_pkg::ADDR_FIFO)
    |=> st_q == pdaps_pkg::PDAPS_ST_AWAKE)
    else $error("fifo read did not wake");
  chk_tape_no_wake: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q == pdaps_pkg::PDAPS_ST_AUTO_PD) && wr_acc && (addr == pdaps_pkg::ADDR_TAPE_SEL)
    && auto_pd_enable |=> st_q == pdaps_pkg::PDAPS_ST_AUTO_PD)
    else $error("non-waking access changed power state");
  chk_int_low_pd: assert property (@(posedge clk_sys) disable iff (rst)
    pd |=> !interrupt && !dma_request)
    else $error("interrupt or request high in powerdown");
  chk_tristate_pd: assert property (@(posedge clk_sys) disable iff (rst)
    pd && !drive_interface_hold |=> !drive_misc_oe && !motor_on_oe[0])
    else $error("drive outputs driven in powerdown");
  chk_inputs_masked: assert property (@(posedge clk_sys) disable iff (rst)
    pd && !index_pulse_n |=> gated_index_pulse_n && !gated_terminal_count)
    else $error("drive input passed in powerdown");
  chk_tape_held: assert property (@(posedge clk_sys) disable iff (rst)
    pd && wr_acc && (addr == pdaps_pkg::ADDR_TAPE_SEL) |=> tdr_q == $past(db_in))
    else $error("write in powerdown not kept");
endmodule

// ### shared/pdaps_pkg.sv
// Package with register map, field positions and timing constants for the powerdown access block.
// Behaviour
// - Non-waking register accesses served in powerdown.
// - Main status read or fifo access wakes.
// - Control writes wake only on motor/reset.
// - Non-waking reads return true current status.
// - Writes in powerdown kept, visible after wake.
// - After non-waking access, return to low power.
// - Extended registers never affect powerdown behaviour.
// - Hold option keeps drive outputs unchanged.
// - Hold cleared: all drive outputs tri-stated.
// - Local logic outputs unaffected by powerdown.
// - Drive, grant and terminal count inputs ignored.
// - Host bus and reset stay fully operational.
// - Powerdown pin high in either powerdown.
// - Idle only: status 80H, head unloaded, no interrupt.
// - Pins encode auto, direct, idle, busy.
// - Status pins replace select one, motor one.
// - Controller states: idle, polling, powerdown; phases.
// - Rate bit 6 enters direct powerdown until reset.
// - Wake restarts timer: 10 ms or 0.5 s.
package pdaps_pkg;
  localparam logic [2:0] ADDR_STATUS_B = 3'h1;
  localparam logic [2:0] ADDR_DRIVE_OUT = 3'h2;
  localparam logic [2:0] ADDR_TAPE_SEL = 3'h3;
  localparam logic [2:0] ADDR_RATE_MAIN = 3'h4;
  localparam logic [2:0] ADDR_FIFO = 3'h5;
  localparam logic [2:0] ADDR_DIGIN_CFG = 3'h7;
  localparam int DOR_RESET_N_BIT = 2;
  localparam int DOR_MOTOR_LO = 4;
  localparam int DOR_MOTOR_HI = 5;
  localparam int DSR_RESET_BIT = 7;
  localparam int DSR_PDOWN_BIT = 6;
  localparam int SRB_MASK_IDLE_BIT = 0;
  localparam logic [7:0] DOR_RESET_VAL = 8'h04;
  localparam logic [7:0] DSR_RESET_VAL = 8'h02;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] MSR_IDLE = 8'h80;
  localparam int CLK_HZ = 25000000;
  localparam int MIN_DLY_SHORT_MS = 10;
  localparam int MIN_DLY_LONG_MS = 500;
  localparam int SHORT_CYCLES = CLK_HZ / 1000 * MIN_DLY_SHORT_MS;
  localparam int LONG_CYCLES = CLK_HZ / 1000 * MIN_DLY_LONG_MS;
  localparam int TMR_W = 24;
  typedef enum logic [1:0] {
    PDAPS_ST_AWAKE = 2'b00,
    PDAPS_ST_AUTO_PD = 2'b01,
    PDAPS_ST_DIRECT_PD = 2'b11
  } pdaps_state_t;
endpackage

// ### hw/pdaps_wake_timer.sv
// Minimum powered-up timer that is restarted on every wake or reset.
`timescale 1ns/10ps
module pdaps_wake_timer #(
  parameter int SHORT_CNT = pdaps_pkg::SHORT_CYCLES,
  parameter int LONG_CNT = pdaps_pkg::LONG_CYCLES
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Control.
  input wire logic restart,
  input wire logic long_dly,
  // Status.
  output logic expired
);
  logic [pdaps_pkg::TMR_W-1:0] cnt_q;

  always_ff @(posedge clk_sys) begin
    if (rst || restart) begin
      cnt_q <= long_dly ? pdaps_pkg::TMR_W'(LONG_CNT) : pdaps_pkg::TMR_W'(SHORT_CNT);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign expired = (cnt_q == '0);
endmodule

// ### bench/pdaps_drive_model.sv
// Behavioural drive model that keeps the raw drive and grant lines busy.
`timescale 1ns/10ps
module pdaps_drive_model (
  // Clock.
  input wire logic clk_sys,
  // Drive and grant lines.
  output logic read_data_n,
  output logic write_protect_n,
  output logic track_zero_n,
  output logic index_pulse_n,
  output logic disk_change_n,
  output logic dma_grant_n,
  output logic terminal_count
);
  logic [2:0] cnt_q = 3'h0;
  // Most lines sit at their active levels, read data toggles and index pulses, so that any leak through the gating shows.
  always @(posedge clk_sys) begin
    cnt_q <= cnt_q + 3'h1;
  end
  assign read_data_n = cnt_q[0];
  assign index_pulse_n = ~(cnt_q == 3'h7);
  assign write_protect_n = 1'b0;
  assign track_zero_n = 1'b0;
  assign disk_change_n = 1'b0;
  assign dma_grant_n = 1'b0;
  assign terminal_count = 1'b1;
endmodule

// ### bench/pdaps_top_bench.sv
// Self-checking bench for the powerdown access block.
`timescale 1ns/10ps
module pdaps_top_bench;
  logic clk_sys, rst, cs_n, rd_n, wr_n, db_oe, head_loaded, core_int, core_dma_request;
  logic [2:0] addr;
  logic [7:0] db_in, db_out, main_status_in, core_fifo_data, digital_input_in, cm, rdat, pls;
  logic auto_pd_enable, min_dly_long, drive_interface_hold, status_pin_enable;
  logic extended_register_enable, core_dir_n, core_step_n, core_write_data_n;
  logic core_write_gate_n, core_head_select_n, read_data_n, write_protect_n, track_zero_n;
  logic index_pulse_n, disk_change_n, dma_grant_n, terminal_count, gated_read_data_n;
  logic gated_write_protect_n, gated_track_zero_n, gated_index_pulse_n, gated_disk_change_n;
  logic gated_dma_grant_n, gated_terminal_count, drive_misc_oe, dma_request, interrupt;
  logic powered_down, core_soft_reset, core_fifo_access;
  logic [1:0] core_motor_on_n, core_drive_select_n, core_density_select, motor_on_n;
  logic [1:0] motor_on_oe, drive_select_n, drive_select_oe, power_state;
  logic [7:0] drive_misc_n, drive_output_control, rate_select_control;
  logic [7:0] configuration_control, tape_drive_select;
  int errors = 0;
  int n_compared = 0;
  assign {core_dir_n, core_step_n, core_write_data_n, core_write_gate_n} = cm[7:4];
  assign core_head_select_n = cm[3];
  assign core_density_select = cm[1:0];
  pdaps_top #(.SHORT_CNT(20), .LONG_CNT(50)) dut (.clk_sys, .rst, .cs_n, .rd_n, .wr_n, .addr,
    .db_in, .db_out, .db_oe, .main_status_in, .head_loaded, .core_int, .core_dma_request,
    .core_fifo_data, .digital_input_in, .auto_pd_enable, .min_dly_long, .drive_interface_hold,
    .status_pin_enable, .extended_register_enable, .core_motor_on_n, .core_drive_select_n,
    .core_dir_n, .core_step_n, .core_write_data_n, .core_write_gate_n, .core_head_select_n,
    .core_density_select, .read_data_n, .write_protect_n, .track_zero_n, .index_pulse_n,
    .disk_change_n, .dma_grant_n, .terminal_count, .gated_read_data_n, .gated_write_protect_n,
    .gated_track_zero_n, .gated_index_pulse_n, .gated_disk_change_n, .gated_dma_grant_n,
    .gated_terminal_count, .motor_on_n, .motor_on_oe, .drive_select_n, .drive_select_oe,
    .drive_misc_n, .drive_misc_oe, .dma_request, .interrupt, .powered_down, .core_soft_reset,
    .core_fifo_access, .drive_output_control, .rate_select_control, .configuration_control,
    .tape_drive_select, .power_state);
  pdaps_drive_model drive (.clk_sys, .read_data_n, .write_protect_n, .track_zero_n,
    .index_pulse_n, .disk_change_n, .dma_grant_n, .terminal_count);
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic end_of_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask
  // One strobe cycle, then one idle edge so that back-to-back calls never merge.
  // The answer and the one-cycle pulses are taken while they stand.
  task automatic acc(input logic wr, input logic [2:0] a, input logic [7:0] d);
    cs_n = 1'b0;
    rd_n = wr;
    wr_n = ~wr;
    addr = a;
    db_in = d;
    tick();
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    rdat = db_out;
    pls = {5'h00, core_soft_reset, core_fifo_access, db_oe};
    tick();
  endtask
  task automatic wait_ps(input logic [1:0] t);
    for (int i = 0; i < 300 && power_state !== t; i++) tick();
    chk("power_state", {6'h00, power_state}, {6'h00, t});
  endtask
  task automatic t_reset;
    chk("dor", drive_output_control, pdaps_pkg::DOR_RESET_VAL);
    chk("dsr", rate_select_control, pdaps_pkg::DSR_RESET_VAL);
    chk("state", {6'h00, power_state}, 8'h00);
    chk("misc", drive_misc_n, cm | 8'h04);
    chk("gin awake", {3'h0, gated_write_protect_n, gated_track_zero_n, gated_disk_change_n,
      gated_dma_grant_n, gated_terminal_count}, 8'h01);
  endtask
  task automatic t_auto_enter;
    auto_pd_enable = 1'b1;
    core_dma_request = 1'b1;
    wait_ps(pdaps_pkg::PDAPS_ST_AUTO_PD);
    for (int i = 0; i < 2; i++) begin
      tick();
      chk("pd", {7'h00, powered_down}, 8'h01);
      chk("oe", {3'h0, drive_misc_oe, motor_on_oe, drive_select_oe}, 8'h00);
      chk("gin", {3'h0, gated_read_data_n, gated_index_pulse_n, gated_track_zero_n,
        gated_write_protect_n, gated_disk_change_n}, 8'h1F);
      chk("gtc", {gated_dma_grant_n, gated_terminal_count, dma_request}, 8'h04);
    end
    core_dma_request = 1'b0;
  endtask
  task automatic t_nonwake;
    acc(1'b1, pdaps_pkg::ADDR_TAPE_SEL, 8'h5A);
    chk("state", {6'h00, power_state}, 8'h01);
    chk("tdr", tape_drive_select, 8'h00);
    acc(1'b0, pdaps_pkg::ADDR_DIGIN_CFG, 8'h00);
    chk("dir", rdat, digital_input_in);
    chk("dir oe", pls, 8'h01);
    chk("state", {6'h00, power_state}, 8'h01);
    acc(1'b1, pdaps_pkg::ADDR_DRIVE_OUT, 8'h0C);
    acc(1'b1, pdaps_pkg::ADDR_RATE_MAIN, 8'h01);
    acc(1'b1, pdaps_pkg::ADDR_DIGIN_CFG, 8'h03);
    chk("state", {6'h00, power_state}, 8'h01);
    acc(1'b0, pdaps_pkg::ADDR_FIFO, 8'h00);
    chk("fifo", rdat, core_fifo_data);
    chk("fifo acc", pls, 8'h03);
    chk("wake", {6'h00, power_state}, 8'h00);
    tick();
    chk("tdr", tape_drive_select, 8'h5A);
    chk("dor", drive_output_control, 8'h0C);
    chk("dsr", rate_select_control, 8'h01);
    chk("ccr", configuration_control, 8'h03);
  endtask
  task automatic t_wakes;
    extended_register_enable = 1'b1;
    for (int k = 0; k < 3; k++) begin
      wait_ps(pdaps_pkg::PDAPS_ST_AUTO_PD);
      if (k == 0) acc(1'b0, pdaps_pkg::ADDR_RATE_MAIN, 8'h00);
      if (k == 1) begin
        acc(1'b1, pdaps_pkg::ADDR_STATUS_B, 8'h5A);
        acc(1'b0, pdaps_pkg::ADDR_STATUS_B, 8'h00);
        chk("srb", rdat, 8'h5A);
        chk("srb state", {6'h00, power_state}, 8'h01);
        acc(1'b1, pdaps_pkg::ADDR_FIFO, 8'h33);
      end
      if (k == 2) acc(1'b1, pdaps_pkg::ADDR_DRIVE_OUT, 8'h1C);
      if (k == 0) chk("msr", rdat, main_status_in);
      chk("state", {6'h00, power_state}, 8'h00);
    end
    acc(1'b1, pdaps_pkg::ADDR_DRIVE_OUT, 8'h0C);
    extended_register_enable = 1'b0;
  endtask
  task automatic t_direct;
    acc(1'b1, pdaps_pkg::ADDR_RATE_MAIN, 8'h40);
    chk("state", {6'h00, power_state}, 8'h03);
    acc(1'b0, pdaps_pkg::ADDR_RATE_MAIN, 8'h00);
    acc(1'b1, pdaps_pkg::ADDR_DRIVE_OUT, 8'h1C);
    chk("state", {6'h00, power_state}, 8'h03);
    chk("pd", {7'h00, powered_down}, 8'h01);
    acc(1'b1, pdaps_pkg::ADDR_RATE_MAIN, 8'h80);
    chk("sreset", pls, 8'h04);
    chk("sreset state", {6'h00, power_state}, 8'h00);
    acc(1'b1, pdaps_pkg::ADDR_DRIVE_OUT, 8'h0C);
  endtask
  task automatic t_hold;
    drive_interface_hold = 1'b1;
    wait_ps(pdaps_pkg::PDAPS_ST_AUTO_PD);
    cm = 8'h5E;
    tick();
    chk("hold oe", {3'h0, drive_misc_oe, motor_on_oe, drive_select_oe}, 8'h1F);
    chk("hold lvl", drive_misc_n, 8'hA5);
    chk("hold sel", {4'h0, motor_on_n, drive_select_n}, 8'h0E);
    cm = 8'hA1;
    acc(1'b0, pdaps_pkg::ADDR_FIFO, 8'h00);
    drive_interface_hold = 1'b0;
  endtask
  // Status pins as {powerdown, idle} on the shared select one and motor one lines.
  task automatic t_pins;
    auto_pd_enable = 1'b0;
    status_pin_enable = 1'b1;
    tick();
    tick();
    chk("idle", {6'h00, drive_select_n[1], motor_on_n[1]}, 8'h01);
    chk("pin oe", {6'h00, drive_select_oe[1], motor_on_oe[1]}, 8'h03);
    main_status_in = 8'h10;
    tick();
    tick();
    chk("busy", {6'h00, drive_select_n[1], motor_on_n[1]}, 8'h00);
    main_status_in = pdaps_pkg::MSR_IDLE;
    core_int = 1'b1;
    tick();
    tick();
    chk("busy int", {6'h00, drive_select_n[1], motor_on_n[1]}, 8'h00);
    chk("int", {7'h00, interrupt}, 8'h01);
    core_int = 1'b0;
    head_loaded = 1'b1;
    tick();
    tick();
    chk("busy head", {6'h00, drive_select_n[1], motor_on_n[1]}, 8'h00);
    head_loaded = 1'b0;
    auto_pd_enable = 1'b1;
    wait_ps(pdaps_pkg::PDAPS_ST_AUTO_PD);
    tick();
    chk("auto", {6'h00, drive_select_n[1], motor_on_n[1]}, 8'h03);
    acc(1'b1, pdaps_pkg::ADDR_RATE_MAIN, 8'h40);
    tick();
    chk("direct", {6'h00, drive_select_n[1], motor_on_n[1]}, 8'h02);
    acc(1'b1, pdaps_pkg::ADDR_RATE_MAIN, 8'h80);
  endtask
  initial begin
    #(40 * 20000);
    errors++;
    end_of_test();
  end
  initial begin
    {rst, cs_n, rd_n, wr_n} = 4'hF;
    addr = 3'h0;
    db_in = 8'h00;
    main_status_in = pdaps_pkg::MSR_IDLE;
    {head_loaded, core_int, core_dma_request} = 3'h0;
    core_fifo_data = 8'hC3;
    digital_input_in = 8'h96;
    {auto_pd_enable, min_dly_long, drive_interface_hold} = 3'h0;
    {status_pin_enable, extended_register_enable} = 2'h0;
    core_motor_on_n = 2'h3;
    core_drive_select_n = 2'h2;
    cm = 8'hA1;
    repeat (8) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    tick();
    t_reset();
    t_auto_enter();
    t_nonwake();
    t_wakes();
    t_direct();
    t_hold();
    t_pins();
    end_of_test();
  end
endmodule
